//--- design/lpdib_burst_order.sv
// Column order generator for one burst, sequential or interleaved
`timescale 1ns/1ps
module lpdib_burst_order
  import lpdib_pkg::*;
#(
  parameter int COL_W = 10  // Column address width
) (
  input  wire logic             hclk,      // System clock
  input  wire logic             hresetn,   // Async reset, active low
  input  wire logic             start,     // Begin a burst
  input  wire logic [COL_W-1:0] start_col, // Starting column
  input  wire logic [2:0]       len_log2,  // Log2 of burst length
  input  wire logic             interleave,// Interleaved order
  output logic      [COL_W-1:0] col,       // Column of this beat
  output logic                  valid,     // Beat present
  output logic                  last       // Final beat
);
  localparam logic [COL_W-1:0] ONE = COL_W'(1);
  logic             active, next_active;     // Burst running
  logic [COL_W-1:0] base, next_base;         // Starting column
  logic [COL_W-1:0] step, next_step;         // Beat index k
  logic [2:0]       lg, next_lg;             // Length code
  logic             il, next_il;             // Order select
  logic [COL_W-1:0] next_col;                // Next output column
  logic             next_valid, next_last;   // Next flags
  logic [COL_W-1:0] mask;                    // Offset bits in block

  // ----------------------------------------------------------------
  // Beat sequencing
  // ----------------------------------------------------------------
  // Each beat stays in the aligned block; offset wraps at its edge
  always_comb begin
    mask = (ONE << lg) - ONE;
    next_active = active;
    next_base = base;
    next_step = step;
    next_lg = lg;
    next_il = il;
    next_valid = active;
    next_last = active && (step == mask);
    if (il) begin
      next_col = base ^ step;
    end else begin
      next_col = ((base + step) & mask) | (base & ~mask);
    end
    if (active) begin
      next_step = step + ONE;
      if (step == mask) begin
        next_active = 1'b0;
      end
    end
    // A new command cuts off a running burst
    if (start) begin
      next_active = 1'b1;
      next_base = start_col;
      next_step = '0;
      next_lg = len_log2;
      next_il = interleave;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active <= 1'b0;
      base <= '0;
      step <= '0;
      lg <= BL_MIN;
      il <= 1'b0;
      col <= '0;
      valid <= 1'b0;
      last <= 1'b0;
    end else begin
      active <= next_active;
      base <= next_base;
      step <= next_step;
      lg <= next_lg;
      il <= next_il;
      col <= next_col;
      valid <= next_valid;
      last <= next_last;
    end
  end
endmodule

//--- design/lpdib_pkg.sv
// Shared constants, command codes, states and carriers for the memory-side init and burst block
package lpdib_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00; // Control
  localparam logic [7:0] REG_STATUS = 8'h04; // Sequence status
  localparam logic [7:0] REG_MODE   = 8'h08; // Standard mode copy
  localparam logic [7:0] REG_EXT    = 8'h0c; // Extended mode copy
  localparam int CTRL_RESTART = 0;           // Write 1: redo power-up
  localparam int CTRL_CHECK   = 1;           // Enable order checking
  localparam int ST_ERR_BIT   = 4;           // Sticky order error, W1C
  localparam logic [1:0] CTRL_RESET = 2'h2;  // Checking on after reset
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ----------------------------------------------------------------
  // Link commands {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MODE = 4'h0; // mode_load_command
  localparam logic [3:0] CMD_REF  = 4'h1; // refresh_command
  localparam logic [3:0] CMD_PRE  = 4'h2; // Precharge
  localparam logic [3:0] CMD_ACT  = 4'h3; // row_open_command
  localparam logic [3:0] CMD_WR   = 4'h4; // Write
  localparam logic [3:0] CMD_RD   = 4'h5; // Read
  localparam logic [3:0] CMD_BST  = 4'h6; // Burst terminate
  localparam logic [3:0] CMD_NOP  = 4'h7; // No operation
  localparam logic [1:0] BANK_STD = 2'h0; // Standard mode select
  localparam logic [1:0] BANK_EXT = 2'h2; // Extended mode select
  localparam int PRE_ALL_BIT = 10;        // Precharge-all address bit
  // ----------------------------------------------------------------
  // Standard mode fields
  // ----------------------------------------------------------------
  localparam int BL_LSB = 0;              // burst_length_setting
  localparam int BT_BIT = 3;              // Burst type, 1 = interleaved
  localparam int RL_LSB = 4;              // read_latency_setting
  localparam int OPM_LSB = 7;             // Operating mode bits
  localparam logic [2:0] BL_MIN = 3'h1;   // Code of length 2
  localparam logic [2:0] BL_MAX = 3'h4;   // Code of length 16
  localparam logic [2:0] RL_TWO = 3'h2;   // Latency two
  localparam logic [2:0] RL_THREE = 3'h3; // Latency three
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;      // hclk period
  localparam int STABLE_TIME_US = 200;      // Least quiet time
  localparam int STABLE_CYCLES =
    (STABLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WAIT  = 3'b000, // Quiet time after clock start
    ST_REF_A = 3'b001, // Precharged, first refresh due
    ST_REF_B = 3'b010, // Second refresh due
    ST_LOAD  = 3'b011, // Mode registers due
    ST_READY = 3'b100, // Normal operation
    ST_SLEEP = 3'b101  // Deepest sleep
  } lpdib_state_type;
  typedef struct packed {
    logic        cke;   // Clock enable
    logic [3:0]  cmd;   // {cs_n, ras_n, cas_n, we_n}
    logic [1:0]  ba;    // Bank address
    logic [12:0] addr;  // Address
  } lpdib_link_type;
endpackage

//--- design/lpdib_top.sv
// Memory-side power-up sequencing, mode registers and burst order with an AHB-Lite slave
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Functional notes
// - After sequence, accept any valid command
// - Bank bits 00 write standard mode
// - Mode kept until reload, sleep, power
// - Mode reload leaves array data intact
// - Burst lengths 2, 4, 8, 16
// - Burst wraps inside aligned column block
// - Same length for reads and writes
// - Mode bit selects sequential or interleaved
// - Sequential: start plus k, modulo length
// - Interleaved: start XOR k
// - Read latency two or three accepted
// - Bank bits 10 write extended mode
module lpdib_top
  import lpdib_pkg::*;
#(
  parameter int COL_W = 10,                   // Column address width
  parameter int STABLE_CNT = STABLE_CYCLES    // Quiet time in hclk cycles
) (
  input  wire logic              hclk,        // System clock
  input  wire logic              hresetn,     // Async reset, active low
  input  wire logic              hsel,        // Slave select
  input  wire logic [31:0]       haddr,       // Byte address
  input  wire logic [1:0]        htrans,      // Transfer type
  input  wire logic              hwrite,      // Write strobe
  input  wire logic [2:0]        hsize,       // Transfer size
  input  wire logic [31:0]       hwdata,      // Write data
  input  wire logic              hready,      // Bus ready
  output logic                   hreadyout,   // Slave ready
  output logic                   hresp,       // Always OKAY
  output logic      [31:0]       hrdata,      // Read data
  input  wire logic              ck_pin,      // Link clock from controller
  input  wire logic              cke_pin,     // Clock enable
  input  wire logic              cs_n_pin,    // Chip select, active low
  input  wire logic              ras_n_pin,   // Row strobe, active low
  input  wire logic              cas_n_pin,   // Column strobe, active low
  input  wire logic              we_n_pin,    // Write enable, active low
  input  wire logic [1:0]        ba_pin,      // Bank address
  input  wire logic [12:0]       addr_pin,    // Address
  output logic                   mem_ready,   // Sequence complete
  output logic      [COL_W-1:0]  burst_col,   // Column of current beat
  output logic                   burst_valid, // Beat present
  output logic                   burst_last,  // Final beat
  output logic                   burst_write  // Burst is a write
);
  localparam int CNT_W = $clog2(STABLE_CNT + 1);
  localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(STABLE_CNT);

  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  lpdib_link_type   link_s1, link_s2;   // Two-stage pin synchroniser
  logic             ck_s1, ck_s2, ck_s3; // Link clock sync and history
  logic             cke_prev;            // Enable at previous ck edge
  logic             ck_rise;             // Rising link clock seen

  // Pins pass two flops before any use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_s1 <= '0;
      link_s2 <= '0;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      cke_prev <= 1'b0;
    end else begin
      link_s1 <= '{cke: cke_pin, cmd: {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin},
                   ba: ba_pin, addr: addr_pin};
      link_s2 <= link_s1;
      ck_s1 <= ck_pin;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      if (ck_rise) begin
        cke_prev <= link_s2.cke;
      end
    end
  end

  assign ck_rise = ck_s2 & ~ck_s3;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  logic             wr_pend, next_wr_pend;     // Write data phase due
  logic [7:0]       wr_addr, next_wr_addr;     // Its register offset
  logic [31:0]      next_hrdata;               // Read data for next phase
  logic [1:0]       ctrl, next_ctrl;           // Control register
  logic             restart;                   // Power-up redo pulse
  logic             err_clear;                 // W1C on order error
  logic [31:0]      status_word;               // Status read view

  // ----------------------------------------------------------------
  // Power-up sequence and mode registers
  // ----------------------------------------------------------------
  lpdib_state_type  state, next_state;         // Sequence state
  logic [CNT_W-1:0] quiet, next_quiet;         // Quiet-time counter
  logic             clk_seen, next_clk_seen;   // First ck edge seen
  logic [12:0]      std_mode, next_std_mode;   // Standard mode
  logic [12:0]      ext_mode, next_ext_mode;   // Extended mode
  logic             std_ok, next_std_ok;       // Standard loaded
  logic             ext_ok, next_ext_ok;       // Extended loaded
  logic             seq_err, next_seq_err;     // Order error, sticky
  logic             rsvd, next_rsvd;           // Reserved mode seen
  logic             next_mem_ready;            // Ready for next cycle
  logic             live;                      // Enable held two edges
  logic             exec;                      // Executable command
  logic             bad;                       // Out-of-order command
  logic             mode_ld;                   // Mode load command
  logic             start;                     // Burst begins
  logic             next_burst_write;          // Direction of new burst

  // Decode the command taken at this link edge
  always_comb begin
    live = ck_rise && cke_prev && link_s2.cke;
    exec = live && (link_s2.cmd[3] == 1'b0) && (link_s2.cmd != CMD_NOP);
    mode_ld = exec && (link_s2.cmd == CMD_MODE);
    bad = 1'b0;
    start = 1'b0;
    next_state = state;
    next_quiet = quiet;
    next_clk_seen = clk_seen;
    next_std_mode = std_mode;
    next_ext_mode = ext_mode;
    next_std_ok = std_ok;
    next_ext_ok = ext_ok;
    next_rsvd = rsvd;
    next_burst_write = burst_write;
    // Quiet time counts from the first enabled link edge
    if (ck_rise && link_s2.cke) begin
      next_clk_seen = 1'b1;
    end
    if (clk_seen && quiet != CNT_DONE) begin
      next_quiet = quiet + CNT_W'(1);
    end
    unique case (state)
      ST_WAIT: begin
        if (exec) begin
          if (quiet == CNT_DONE && link_s2.cmd == CMD_PRE
              && link_s2.addr[PRE_ALL_BIT]) begin
            next_state = ST_REF_A;
          end else begin
            bad = 1'b1;
          end
        end
      end
      ST_REF_A: begin
        if (exec && link_s2.cmd == CMD_REF) begin
          next_state = ST_REF_B;
        end else if (exec && link_s2.cmd != CMD_PRE) begin
          bad = 1'b1;
        end
      end
      ST_REF_B: begin
        if (exec && link_s2.cmd == CMD_REF) begin
          next_state = ST_LOAD;
        end else if (exec) begin
          bad = 1'b1;
        end
      end
      ST_LOAD: begin
        if (exec && !mode_ld) begin
          bad = 1'b1;
        end
        // Both loads done, in either order
        if ((std_ok || (mode_ld && link_s2.ba == BANK_STD))
            && (ext_ok || (mode_ld && link_s2.ba == BANK_EXT))) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        // Any valid command is now accepted
        if (exec && (link_s2.cmd == CMD_RD || link_s2.cmd == CMD_WR)
            && std_mode[BL_LSB +: 3] >= BL_MIN
            && std_mode[BL_LSB +: 3] <= BL_MAX) begin
          start = 1'b1;
          next_burst_write = (link_s2.cmd == CMD_WR);
        end
        // Enable falling with burst terminate enters deepest sleep
        if (ck_rise && cke_prev && !link_s2.cke
            && link_s2.cmd == CMD_BST) begin
          next_state = ST_SLEEP;
          next_std_ok = 1'b0;
          next_ext_ok = 1'b0;
          next_std_mode = '0;
          next_ext_mode = '0;
        end
      end
      ST_SLEEP: begin
        // Leaving sleep needs the whole sequence again
        if (ck_rise && link_s2.cke) begin
          next_state = ST_WAIT;
          next_quiet = '0;
        end
      end
    endcase
    // Mode loads touch only the mode copies, never the array
    if (mode_ld && (state == ST_LOAD || state == ST_READY)) begin
      if (link_s2.ba == BANK_STD) begin
        next_std_mode = link_s2.addr;
        next_std_ok = 1'b1;
        next_rsvd = (link_s2.addr[BL_LSB +: 3] < BL_MIN)
          || (link_s2.addr[BL_LSB +: 3] > BL_MAX)
          || (link_s2.addr[RL_LSB +: 3] != RL_TWO
              && link_s2.addr[RL_LSB +: 3] != RL_THREE)
          || (link_s2.addr[12:OPM_LSB] != '0);
      end else if (link_s2.ba == BANK_EXT) begin
        next_ext_mode = link_s2.addr;
        next_ext_ok = 1'b1;
      end
    end
    // Software power-up redo models a supply interruption
    if (restart) begin
      next_state = ST_WAIT;
      next_quiet = '0;
      next_clk_seen = 1'b0;
      next_std_ok = 1'b0;
      next_ext_ok = 1'b0;
      next_std_mode = '0;
      next_ext_mode = '0;
      next_rsvd = 1'b0;
    end
    // Set wins over the software clear
    next_seq_err = seq_err && !err_clear;
    if (bad && ctrl[CTRL_CHECK]) begin
      next_seq_err = 1'b1;
    end
    next_mem_ready = (next_state == ST_READY);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_WAIT;
      quiet <= '0;
      clk_seen <= 1'b0;
      std_mode <= '0;
      ext_mode <= '0;
      std_ok <= 1'b0;
      ext_ok <= 1'b0;
      seq_err <= 1'b0;
      rsvd <= 1'b0;
      mem_ready <= 1'b0;
      burst_write <= 1'b0;
    end else begin
      state <= next_state;
      quiet <= next_quiet;
      clk_seen <= next_clk_seen;
      std_mode <= next_std_mode;
      ext_mode <= next_ext_mode;
      std_ok <= next_std_ok;
      ext_ok <= next_ext_ok;
      seq_err <= next_seq_err;
      rsvd <= next_rsvd;
      mem_ready <= next_mem_ready;
      burst_write <= next_burst_write;
    end
  end

  // ----------------------------------------------------------------
  // Burst column order
  // ----------------------------------------------------------------
  lpdib_burst_order #(
    .COL_W(COL_W)
  ) u_order (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .start      (start),
    .start_col  (link_s2.addr[COL_W-1:0]),
    .len_log2   (std_mode[BL_LSB +: 3]),
    .interleave (std_mode[BT_BIT]),
    .col        (burst_col),
    .valid      (burst_valid),
    .last       (burst_last)
  );

  // ----------------------------------------------------------------
  // AHB-Lite register access
  // ----------------------------------------------------------------
  // Zero-wait slave: read data is fetched in the address phase
  always_comb begin
    status_word = '0;
    status_word[2:0] = state;
    status_word[3] = mem_ready;
    status_word[ST_ERR_BIT] = seq_err;
    status_word[5] = rsvd;
    status_word[6] = std_ok;
    status_word[7] = ext_ok;
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_hrdata = '0;
    next_ctrl = ctrl;
    restart = 1'b0;
    err_clear = 1'b0;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      if (hwrite) begin
        next_wr_pend = 1'b1;
        next_wr_addr = haddr[7:0];
      end else begin
        unique case (haddr[7:0])
          REG_CTRL:   next_hrdata = {30'h0, ctrl};
          REG_STATUS: next_hrdata = status_word;
          REG_MODE:   next_hrdata = {19'h0, std_mode};
          REG_EXT:    next_hrdata = {19'h0, ext_mode};
          default:    next_hrdata = '0;
        endcase
      end
    end
    // Write data phase; unmapped offsets are ignored
    if (wr_pend) begin
      if (wr_addr == REG_CTRL) begin
        next_ctrl[CTRL_CHECK] = hwdata[CTRL_CHECK];
        restart = hwdata[CTRL_RESTART];
      end
      if (wr_addr == REG_STATUS) begin
        err_clear = hwdata[ST_ERR_BIT];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= '0;
      ctrl <= CTRL_RESET;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      ctrl <= next_ctrl;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule

//--- testbench/lpdib_checker.sv
// Port checker for the bus answer and the burst beat stream
`timescale 1ns/1ps
module lpdib_checker
  import lpdib_pkg::*;
#(
  parameter int COL_W = 10  // Column address width
) (
  input wire logic             hclk,        // System clock
  input wire logic             hresetn,     // Async reset, active low
  input wire logic             hreadyout,   // Slave ready
  input wire logic             hresp,       // Response
  input wire logic             mem_ready,   // Sequence complete
  input wire logic [COL_W-1:0] burst_col,   // Beat column
  input wire logic             burst_valid, // Beat present
  input wire logic             burst_last,  // Final beat
  input wire logic             burst_write  // Write burst
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [4:0] beats;      // Beats before the last one
  logic [4:0] next_beats; // Next count
  // Count beats, clear on the last
  always_comb begin
    next_beats = beats;
    if (burst_last)
      next_beats = 5'h0;
    else if (burst_valid)
      next_beats = beats + 5'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      beats <= 5'h0;
    else
      beats <= next_beats;
  end
  property p_okay; hreadyout && !hresp; endproperty
  property p_rdy; burst_valid |-> mem_ready; endproperty
  property p_run; burst_valid && !burst_last |=> burst_valid; endproperty
  property p_len; burst_last |-> beats inside {5'h1, 5'h3, 5'h7, 5'h0f}; endproperty
  property p_blk; burst_valid && !burst_last |=> $stable(burst_col[COL_W-1:4]); endproperty
  property p_dir; burst_valid && !burst_last |=> $stable(burst_write); endproperty
  property p_step; burst_valid && !burst_last |=> burst_col[0] != $past(burst_col[0]); endproperty
  property p_end; burst_last |=> !burst_valid; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  a_rdy: assert property (p_rdy) else $error("beat before sequence done");
  a_run: assert property (p_run) else $error("gap inside burst");
  a_len: assert property (p_len) else $error("burst beat count wrong");
  a_blk: assert property (p_blk) else $error("burst left its block");
  a_dir: assert property (p_dir) else $error("direction changed in burst");
  a_step: assert property (p_step) else $error("low column bit not toggling");
  a_end: assert property (p_end) else $error("beat after last");
  c_wr: cover property (burst_last && burst_write);
  c_long: cover property (burst_last && beats == 5'h0f);
  c_up: cover property ($rose(mem_ready));
endmodule
bind lpdib_top lpdib_checker #(.COL_W(COL_W)) i_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .mem_ready(mem_ready), .burst_col(burst_col),
  .burst_valid(burst_valid), .burst_last(burst_last), .burst_write(burst_write));

//--- testbench/lpdib_ctrl_model.sv
// Controller model: link clock, clock enable and command sequencing
`timescale 1ns/1ps
module lpdib_ctrl_model
  import lpdib_pkg::*;
#(
  parameter int QUIET_CK = 2  // NOP steps, two clocks each, before the first command
) (
  output logic           ck_pin, // Link clock
  output lpdib_link_type link    // Enable, command, bank, address
);
  // Enable high first, clock starts after it
  initial begin
    link = '{1'b1, CMD_NOP, 2'h0, 13'h0};
    ck_pin = 1'b0;
    #101.3;
    forever #62.5 ck_pin = ~ck_pin;
  end
  // One command for one clock, then NOP with moving address lines
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic [12:0] a, input logic e = 1'b1);
    @(negedge ck_pin);
    link <= '{e, c, b, a};
    @(negedge ck_pin);
    link <= '{1'b1, CMD_NOP, ~b, ~a};
  endtask
  // Full power-up, one NOP clock after each step
  task automatic power_up(input logic [12:0] sm, input logic [12:0] em);
    repeat (QUIET_CK) issue(CMD_NOP, 2'h0, 13'h0);
    issue(CMD_PRE, 2'h0, 13'h400);
    repeat (2) issue(CMD_REF, 2'h0, 13'h0);
    issue(CMD_MODE, BANK_EXT, em);
    issue(CMD_MODE, BANK_STD, sm);
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench: power-up, mode loads, burst orders, registers
`timescale 1ns/1ps
module tb;
  import lpdib_pkg::*;
  logic           hclk, hresetn, hsel, hwrite, hreadyout, hresp; // Bus control
  logic [1:0]     htrans;                  // Transfer type
  logic [2:0]     hsize;                   // Transfer size
  logic [31:0]    haddr, hwdata, hrdata, r; // Bus words, read result
  logic           ck, mem_ready, bval, blast, bwr; // Link clock, flags
  logic [9:0]     bcol;                    // Beat column
  logic [9:0]     q[$];                    // Columns seen
  logic [12:0]    md;                      // Mode value sent
  lpdib_link_type lk;                      // Controller pins
  int             n_fail, checks, seed, i, k, n, st; // Counters
  lpdib_top #(.COL_W(10), .STABLE_CNT(20)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ck_pin(ck), .cke_pin(lk.cke), .cs_n_pin(lk.cmd[3]),
    .ras_n_pin(lk.cmd[2]), .cas_n_pin(lk.cmd[1]), .we_n_pin(lk.cmd[0]), .ba_pin(lk.ba),
    .addr_pin(lk.addr), .mem_ready(mem_ready), .burst_col(bcol), .burst_valid(bval),
    .burst_last(blast), .burst_write(bwr));
  lpdib_ctrl_model #(.QUIET_CK(2)) i_ctrl (.ck_pin(ck), .link(lk));
  // Clock and beat collector
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk)
    if (bval === 1'b1) q.push_back(bcol);
  // Verdict and end of run
  task automatic end_of_test();
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single AHB-Lite transfer, read word left in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Reference column of beat j
  function automatic int ecol(int s, int len, int il, int j);
    int o;
    o = s % len;
    return s - o + (il ? (o ^ j) : ((o + j) % len));
  endfunction
  task automatic up_chk();
    i_ctrl.power_up(13'h22, 13'h20);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'hcc, r);
    chk("ready", 32'h1, mem_ready);
    bus(1'b0, REG_EXT, 32'h0);
    chk("ext", 32'h20, r);
  endtask
  // Watchdog
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
  initial begin
    seed = 73;
    n_fail = 0;
    checks = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (k = 0; k < 5; k++) begin
      bus(1'b0, 8'(k * 4), 32'h0);
      chk("reset", k == 0 ? 32'h2 : 32'h0, r);
    end
    up_chk();
    for (i = 0; i < 16; i++) begin
      md = {6'h0, (i < 8 ? RL_TWO : RL_THREE), 1'(i / 4 % 2), 3'(i % 4 + 1)};
      i_ctrl.issue(CMD_MODE, BANK_STD, md);
      bus(1'b0, REG_MODE, 32'h0);
      chk("mode", {19'h0, md}, r);
      bus(1'b0, REG_STATUS, 32'h0);
      chk("status", 32'hcc, r);
      st = $unsigned($random(seed)) % 1024;
      n = 2 << (i % 4);
      q.delete();
      i_ctrl.issue(i < 8 ? CMD_RD : CMD_WR, 2'($random(seed)), 13'(st));
      @(negedge ck);
      chk("beats", n, q.size());
      chk("write", i / 8, bwr);
      for (k = 0; k < n; k++)
        chk("col", ecol(st, n, i / 4 % 2, k), q[k]);
    end
    i_ctrl.issue(CMD_MODE, 2'h1, 13'h7f);
    bus(1'b1, REG_MODE, 32'h1fff);
    bus(1'b0, REG_MODE, 32'h0);
    chk("kept", {19'h0, md}, r);
    i_ctrl.issue(CMD_BST, 2'h0, 13'h0, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("sleep", 32'h5, r & 32'hf);
    bus(1'b0, REG_MODE, 32'h0);
    chk("cleared", 32'h0, r);
    up_chk();
    bus(1'b1, REG_CTRL, 32'h3);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("restart", 32'h0, r);
    chk("not ready", 32'h0, mem_ready);
    // Early refresh, after the quiet time but before any precharge, sets the sticky order error
    i_ctrl.issue(CMD_REF, 2'h0, 13'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("order error", 32'h10, r);
    bus(1'b1, REG_STATUS, 32'h10);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("error clear", 32'h0, r);
    end_of_test();
  end
endmodule
